// File: common/vpic_cfg.svh
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH

// ----------------------------------------
// source map
// ----------------------------------------
`define VPIC_NUM_SRC      24
`define VPIC_NUM_GRP      6
`define VPIC_NUM_LVL      4
`define VPIC_SRC_EXT_A    5
`define VPIC_SRC_UNUSED_A 7
`define VPIC_SRC_UNUSED_B 23
// external b inputs 0..3 feed these sources
`define VPIC_SRC_EXT_B0   0
`define VPIC_SRC_EXT_B1   1
`define VPIC_SRC_EXT_B2   6
`define VPIC_SRC_EXT_B3   11

// ----------------------------------------
// vectors
// ----------------------------------------
`define VPIC_VEC_RESET    16'h0000
`define VPIC_VEC_BASE     16'h0003
`define VPIC_VEC_SHIFT    3

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define VPIC_EA_BIT       7
`define VPIC_REG_RESET    8'h00

// ----------------------------------------
// edge select codes
// ----------------------------------------
`define VPIC_EDGE_NONE    2'h0
`define VPIC_EDGE_RISE    2'h1
`define VPIC_EDGE_FALL    2'h2
`define VPIC_EDGE_BOTH    2'h3

`endif

// File: common/vpic_pkg.sv
`default_nettype none

package vpic_pkg;

	// ----------------------------------------
	// register write targets
	// ----------------------------------------
	typedef enum logic [3:0] {
		VPIC_SEL_ENABLE_0,
		VPIC_SEL_ENABLE_1,
		VPIC_SEL_ENABLE_2,
		VPIC_SEL_ENABLE_3,
		VPIC_SEL_PRIO_LOW,
		VPIC_SEL_PRIO_HIGH,
		VPIC_SEL_POWER_CTRL,
		VPIC_SEL_FLAGS_A,
		VPIC_SEL_FLAGS_B,
		VPIC_SEL_EDGE_A_LOW,
		VPIC_SEL_EDGE_A_HIGH,
		VPIC_SEL_EDGE_B
	} vpic_reg_sel_t;

	// ----------------------------------------
	// delivery states
	// ----------------------------------------
	typedef enum logic {
		VPIC_ST_IDLE,
		VPIC_ST_OFFER
	} vpic_state_t;

endpackage

`default_nettype wire

// File: design/vpic_top.sv
// What this block does
// - every enabled request raises wake-up for stop or idle, whatever its level.
// - a pending request is not delivered in a cycle that writes an enable, priority or power control register.
// - 24 sources, each with enable bit and vector 0003H plus eight per source.
// - external inputs 0..7 merge into source 5, enabled by enable 0 bit 5.
// - core long-calls; block supplies the vector address of the serviced source.
// - a request is taken only with global enable and its own enable both set.
// - request flag holds until accepted, then clears itself.
// - latched request stays until accepted, reset, or cleared by an instruction.
// - acceptance happens at the last cycle of an instruction.
// - instruction end to service entry takes 3 to 9 machine cycles.
// - return from service restores the interrupted level context.
// - sampled at instruction last cycle; vector low byte chosen; ack next cycle.
// - of simultaneous requests the higher level is granted first.
// - a routine is preempted only by a strictly higher level.
// - at equal level the lowest-numbered source wins.
// - six groups of four sources, each group at level 0..3, 3 highest.
// - both priority registers reset to 00H, all groups at level 0.
// - external pending flag sets on its chosen edge, clears on service entry.
// - writing zero to an external pending flag bit clears it.
// - each external input selects rising, falling or both edges; none after reset.
// - global enable clears on vector entry and sets on return from service.
// - source n sits in group n modulo six; lower number ranks higher.
// - group level is high-register bit over low-register bit.
// - edge field 00 none, 01 rising, 10 falling, 11 both.
`include "vpic_cfg.svh"
`default_nettype none

module vpic_top #(
	parameter int NUM_SRC = `VPIC_NUM_SRC,
	parameter int NUM_GRP = `VPIC_NUM_GRP
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// register writes
	input  wire logic                  reg_wr_en,
	input  wire vpic_pkg::vpic_reg_sel_t reg_wr_sel,
	input  wire logic [7:0]            reg_wr_data,
	// request latch clear by instruction
	input  wire logic                  req_clr_en,
	input  wire logic [4:0]            req_clr_idx,
	// peripheral requests and external pins
	input  wire logic [NUM_SRC-1:0]    src_req,
	input  wire logic [7:0]            ext_pin_a,
	input  wire logic [3:0]            ext_pin_b,
	// core handshake
	input  wire logic                  instr_last,
	input  wire logic                  irq_ack,
	input  wire logic                  return_from_isr,
	output logic                       irq_req,
	output logic [15:0]                vector_addr,
	output logic [7:0]                 vector_low_byte,
	// status
	output logic                       global_irq_enable,
	output logic [7:0]                 ext_pending_flags_a,
	output logic [3:0]                 ext_pending_flags_b,
	output logic [NUM_SRC-1:0]         req_flags,
	output logic [3:0]                 in_service_levels,
	output logic                       wake_up
);
	import vpic_pkg::*;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [NUM_SRC-1:0] src_enable;
	logic [7:0]         priority_low_bits;
	logic [7:0]         priority_high_bits;
	logic [15:0]        edge_sel_a;
	logic [7:0]         edge_sel_b;
	vpic_state_t        state;
	logic [4:0]         offer_idx;
	logic [1:0]         offer_lvl;

	logic write_hold;
	assign write_hold = reg_wr_en && (reg_wr_sel == VPIC_SEL_ENABLE_0 ||
		reg_wr_sel == VPIC_SEL_ENABLE_1 || reg_wr_sel == VPIC_SEL_ENABLE_2 ||
		reg_wr_sel == VPIC_SEL_ENABLE_3 || reg_wr_sel == VPIC_SEL_PRIO_LOW ||
		reg_wr_sel == VPIC_SEL_PRIO_HIGH || reg_wr_sel == VPIC_SEL_POWER_CTRL);

	logic take_ack;
	assign take_ack = (state == VPIC_ST_OFFER) && irq_ack;

	always_ff @(posedge clk) begin
		if (rst) begin
			src_enable <= '0;
		end else if (reg_wr_en) begin
			unique case (reg_wr_sel)
				VPIC_SEL_ENABLE_0: src_enable[5:0]   <= reg_wr_data[5:0];
				VPIC_SEL_ENABLE_1: src_enable[11:6]  <= reg_wr_data[5:0];
				VPIC_SEL_ENABLE_2: src_enable[17:12] <= reg_wr_data[5:0];
				VPIC_SEL_ENABLE_3: src_enable[23:18] <= reg_wr_data[5:0];
				default: ;
			endcase
		end
	end

	// hardware entry and return outrank a software write of the bit
	always_ff @(posedge clk) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
		end else if (take_ack) begin
			global_irq_enable <= 1'b0;
		end else if (return_from_isr) begin
			global_irq_enable <= 1'b1;
		end else if (reg_wr_en && reg_wr_sel == VPIC_SEL_ENABLE_0) begin
			global_irq_enable <= reg_wr_data[`VPIC_EA_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			priority_low_bits  <= `VPIC_REG_RESET;
			priority_high_bits <= `VPIC_REG_RESET;
		end else if (reg_wr_en && reg_wr_sel == VPIC_SEL_PRIO_LOW) begin
			priority_low_bits <= reg_wr_data;
		end else if (reg_wr_en && reg_wr_sel == VPIC_SEL_PRIO_HIGH) begin
			priority_high_bits <= reg_wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			edge_sel_a <= '0;
			edge_sel_b <= `VPIC_REG_RESET;
		end else if (reg_wr_en) begin
			unique case (reg_wr_sel)
				VPIC_SEL_EDGE_A_LOW:  edge_sel_a[7:0]  <= reg_wr_data;
				VPIC_SEL_EDGE_A_HIGH: edge_sel_a[15:8] <= reg_wr_data;
				VPIC_SEL_EDGE_B:      edge_sel_b       <= reg_wr_data;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// external edge detection
	// ----------------------------------------
	logic [7:0] pin_a_prev;
	logic [3:0] pin_b_prev;
	logic [7:0] edge_a;
	logic [3:0] edge_b;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_a_prev <= '0;
			pin_b_prev <= '0;
		end else begin
			pin_a_prev <= ext_pin_a;
			pin_b_prev <= ext_pin_b;
		end
	end

	function automatic logic edge_hit(input logic [1:0] mode, input logic now,
		input logic prev);
		logic rise;
		logic fall;
		rise = now & ~prev;
		fall = ~now & prev;
		unique case (mode)
			`VPIC_EDGE_NONE: edge_hit = 1'b0;
			`VPIC_EDGE_RISE: edge_hit = rise;
			`VPIC_EDGE_FALL: edge_hit = fall;
			`VPIC_EDGE_BOTH: edge_hit = rise | fall;
		endcase
	endfunction

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			edge_a[i] = edge_hit(edge_sel_a[2*i +: 2], ext_pin_a[i], pin_a_prev[i]);
		end
		for (int i = 0; i < 4; i++) begin
			edge_b[i] = edge_hit(edge_sel_b[2*i +: 2], ext_pin_b[i], pin_b_prev[i]);
		end
	end

	// ----------------------------------------
	// external pending flags
	// ----------------------------------------
	logic [7:0] clr_a;
	logic [3:0] clr_b;

	always_comb begin
		clr_a = '0;
		clr_b = '0;
		if (reg_wr_en && reg_wr_sel == VPIC_SEL_FLAGS_A) begin
			clr_a = ~reg_wr_data;
		end
		if (reg_wr_en && reg_wr_sel == VPIC_SEL_FLAGS_B) begin
			clr_b = ~reg_wr_data[3:0];
		end
		if (take_ack && offer_idx == 5'(`VPIC_SRC_EXT_A)) begin
			clr_a = 8'hFF;
		end
		if (take_ack) begin
			clr_b[0] = clr_b[0] | (offer_idx == 5'(`VPIC_SRC_EXT_B0));
			clr_b[1] = clr_b[1] | (offer_idx == 5'(`VPIC_SRC_EXT_B1));
			clr_b[2] = clr_b[2] | (offer_idx == 5'(`VPIC_SRC_EXT_B2));
			clr_b[3] = clr_b[3] | (offer_idx == 5'(`VPIC_SRC_EXT_B3));
		end
	end

	// a new edge in the clearing cycle is kept
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_pending_flags_a <= `VPIC_REG_RESET;
			ext_pending_flags_b <= '0;
		end else begin
			ext_pending_flags_a <= (ext_pending_flags_a & ~clr_a) | edge_a;
			ext_pending_flags_b <= (ext_pending_flags_b & ~clr_b) | edge_b;
		end
	end

	// ----------------------------------------
	// request latches
	// ----------------------------------------
	logic [NUM_SRC-1:0] src_set;
	logic [NUM_SRC-1:0] src_clr;
	logic [NUM_SRC-1:0] live_req;

	always_comb begin
		src_set = src_req;
		src_set[`VPIC_SRC_UNUSED_A] = 1'b0;
		src_set[`VPIC_SRC_UNUSED_B] = 1'b0;
		src_clr = '0;
		if (req_clr_en) begin
			src_clr[req_clr_idx] = 1'b1;
		end
		if (take_ack) begin
			src_clr[offer_idx] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			req_flags <= '0;
		end else begin
			req_flags <= (req_flags & ~src_clr) | src_set;
		end
	end

	// external sources are driven by their pending flags
	always_comb begin
		live_req = req_flags;
		live_req[`VPIC_SRC_EXT_A]  = |ext_pending_flags_a;
		live_req[`VPIC_SRC_EXT_B0] = ext_pending_flags_b[0];
		live_req[`VPIC_SRC_EXT_B1] = ext_pending_flags_b[1];
		live_req[`VPIC_SRC_EXT_B2] = ext_pending_flags_b[2];
		live_req[`VPIC_SRC_EXT_B3] = ext_pending_flags_b[3];
		live_req = live_req & src_enable;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wake_up <= 1'b0;
		end else begin
			wake_up <= |live_req;
		end
	end

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	logic [1:0] best_lvl;
	logic [4:0] best_idx;
	logic       best_found;
	logic [1:0] cur_lvl;
	logic       can_preempt;

	// scan from high numbers down so an equal level lets the lower number win
	always_comb begin
		logic [1:0] lvl;
		int         grp;
		best_lvl   = '0;
		best_idx   = '0;
		best_found = 1'b0;
		lvl        = '0;
		grp        = 0;
		for (int n = NUM_SRC - 1; n >= 0; n--) begin
			grp = n % NUM_GRP;
			lvl = {priority_high_bits[grp], priority_low_bits[grp]};
			if (live_req[n] && (!best_found || lvl >= best_lvl)) begin
				best_lvl   = lvl;
				best_idx   = 5'(n);
				best_found = 1'b1;
			end
		end
	end

	always_comb begin
		cur_lvl = '0;
		for (int l = 0; l < 4; l++) begin
			if (in_service_levels[l]) begin
				cur_lvl = 2'(l);
			end
		end
		can_preempt = ~|in_service_levels || (best_lvl > cur_lvl);
	end

	// ----------------------------------------
	// delivery to the core
	// ----------------------------------------
	logic take_new;
	assign take_new = (state == VPIC_ST_IDLE) && instr_last && best_found &&
		global_irq_enable && can_preempt && !write_hold;

	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= VPIC_ST_IDLE;
			irq_req   <= 1'b0;
			offer_idx <= '0;
			offer_lvl <= '0;
		end else begin
			unique case (state)
				VPIC_ST_IDLE: begin
					if (take_new) begin
						state     <= VPIC_ST_OFFER;
						irq_req   <= 1'b1;
						offer_idx <= best_idx;
						offer_lvl <= best_lvl;
					end
				end
				VPIC_ST_OFFER: begin
					if (irq_ack) begin
						state   <= VPIC_ST_IDLE;
						irq_req <= 1'b0;
					end
				end
			endcase
		end
	end

	// reset leaves the vector at zero, the non-maskable entry
	always_ff @(posedge clk) begin
		if (rst) begin
			vector_addr     <= `VPIC_VEC_RESET;
			vector_low_byte <= 8'(`VPIC_VEC_RESET);
		end else if (take_new) begin
			vector_addr     <= `VPIC_VEC_BASE + (16'(best_idx) << `VPIC_VEC_SHIFT);
			vector_low_byte <= 8'(`VPIC_VEC_BASE + (16'(best_idx) << `VPIC_VEC_SHIFT));
		end
	end

	// ----------------------------------------
	// nesting context
	// ----------------------------------------
	logic [3:0] top_bit;

	always_comb begin
		top_bit = '0;
		for (int l = 0; l < 4; l++) begin
			if (in_service_levels[l]) begin
				top_bit = 4'h1 << l;
			end
		end
	end

	// entry and return in one cycle: the new level is nested, old top drops
	always_ff @(posedge clk) begin
		if (rst) begin
			in_service_levels <= '0;
		end else begin
			in_service_levels <= (in_service_levels &
				~(return_from_isr ? top_bit : 4'h0)) |
				(take_ack ? (4'h1 << offer_lvl) : 4'h0);
		end
	end

endmodule

`default_nettype wire

// File: verification/vpic_props.sv
`default_nettype none

module vpic_props (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// core and register inputs
	input wire logic                   reg_wr_en,
	input wire vpic_pkg::vpic_reg_sel_t reg_wr_sel,
	input wire logic                   instr_last,
	input wire logic                   irq_ack,
	input wire logic                   return_from_isr,
	// controller answers
	input wire logic                   irq_req,
	input wire logic [15:0]            vector_addr,
	input wire logic [7:0]             vector_low_byte,
	input wire logic                   global_irq_enable,
	input wire logic [7:0]             ext_pending_flags_a,
	input wire logic [3:0]             in_service_levels
);
	import vpic_pkg::*;
	logic blk;
	// ------
	// checks
	// ------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// flag writes and edge selects do not hold delivery
	assign blk = reg_wr_en && (reg_wr_sel <= VPIC_SEL_POWER_CTRL);
	sequence offer_s; $rose(irq_req); endsequence
	sequence taken_s; irq_req && irq_ack && !return_from_isr; endsequence
	offer_hold_a: assert property (irq_req && !irq_ack |=> irq_req && $stable(vector_addr))
		else $error("offer dropped before ack");
	offer_cause_a: assert property (offer_s |-> $past(instr_last) && $past(global_irq_enable) && !$past(blk))
		else $error("offer without cause");
	ack_entry_a: assert property (taken_s |=> !irq_req && !global_irq_enable)
		else $error("entry left offer or enable");
	nest_up_a: assert property (taken_s |=> in_service_levels > $past(in_service_levels))
		else $error("entry did not raise level");
	return_a: assert property (return_from_isr && !irq_ack |=> global_irq_enable && in_service_levels < $past(in_service_levels))
		else $error("return did not restore");
	low_byte_a: assert property (irq_req |-> vector_low_byte == vector_addr[7:0])
		else $error("low byte differs");
	vec_range_a: assert property (offer_s |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h00BB)
		else $error("vector outside table");
	no_unused_a: assert property (offer_s |-> vector_addr != 16'h003B && vector_addr != 16'h00BB)
		else $error("unused source offered");
	ext_clear_a: assert property ((taken_s and (vector_addr == 16'h002B)) |=> ext_pending_flags_a == 8'h00)
		else $error("pending flags kept");
	reset_vec_a: assert property ($fell(rst) |-> !irq_req && vector_addr == 16'h0000 && !global_irq_enable)
		else $error("reset state wrong");
endmodule

bind vpic_top vpic_props u_props (.clk, .rst, .reg_wr_en, .reg_wr_sel, .instr_last, .irq_ack,
	.return_from_isr, .irq_req, .vector_addr, .vector_low_byte, .global_irq_enable,
	.ext_pending_flags_a, .in_service_levels);

`default_nettype wire

// File: verification/vpic_core_model.sv
`default_nettype none

module vpic_core_model #(
	parameter int ISR_LEN = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control
	input wire logic slow,
	// controller side
	input wire logic irq_req,
	output logic     instr_last,
	output logic     irq_ack,
	output logic     return_from_isr
);
	timeunit 1ns;
	timeprecision 1ns;
	int phase = 0;
	int wait_n = 0;
	int depth = 0;
	int busy_n = 0;
	initial begin
		instr_last = 1'b0;
		irq_ack = 1'b0;
		return_from_isr = 1'b0;
	end
	// three-cycle instructions; no new last cycle while an offer waits
	always @(negedge clk) begin
		irq_ack <= 1'b0;
		return_from_isr <= 1'b0;
		phase <= (phase + 1) % 3;
		instr_last <= phase == 0 && irq_req !== 1'b1;
		if (rst) begin
			depth <= 0;
			busy_n <= 0;
		end else if (irq_req === 1'b1 && !irq_ack) begin
			wait_n <= wait_n + 1;
			if (wait_n >= (slow ? 4 : 0)) begin
				irq_ack <= 1'b1;
				wait_n <= 0;
				depth <= depth + 1;
				busy_n <= 0;
			end
		end else if (depth > 0) begin
			busy_n <= busy_n + 1;
			if (busy_n == ISR_LEN) begin
				return_from_isr <= 1'b1;
				depth <= depth - 1;
				busy_n <= 0;
			end
		end
	end
endmodule

`default_nettype wire

// File: verification/vpic_top_test.sv
`default_nettype none

module vpic_top_test import vpic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, reg_wr_en = 0, req_clr_en = 0, slow = 0, prev_req = 0;
	vpic_reg_sel_t reg_wr_sel = VPIC_SEL_ENABLE_0;
	logic [7:0] reg_wr_data = 8'h00, ext_pin_a = 8'h00, fa;
	logic [4:0] req_clr_idx = 5'h00;
	logic [23:0] src_req = 24'h000000, req_flags;
	logic [3:0] ext_pin_b = 4'h0, fb, isl;
	logic instr_last, irq_ack, ret, irq_req, ea, wake;
	logic [15:0] vec;
	logic [5:0] pl, ph;
	logic [15:0] exp_q[$];
	int n_errors = 0, checked = 0, a, b, w;
	int ok_src[17] = '{2, 3, 4, 8, 9, 10, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 22};

	vpic_top dut (.clk, .rst, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .req_clr_en, .req_clr_idx,
		.src_req, .ext_pin_a, .ext_pin_b, .instr_last, .irq_ack, .return_from_isr(ret),
		.irq_req, .vector_addr(vec), .vector_low_byte(), .global_irq_enable(ea),
		.ext_pending_flags_a(fa), .ext_pending_flags_b(fb), .req_flags,
		.in_service_levels(isl), .wake_up(wake));
	vpic_core_model #(.ISR_LEN(40)) core (.clk, .rst, .slow, .irq_req, .instr_last, .irq_ack,
		.return_from_isr(ret));

	initial forever #20 clk = ~clk;

	// ------
	// tasks
	// ------
	task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(vpic_reg_sel_t s, logic [7:0] d);
		reg_wr_sel = s;
		reg_wr_data = d;
		reg_wr_en = 1;
		@(negedge clk);
		reg_wr_en = 0;
		@(negedge clk);
	endtask
	task automatic pulse(int n);
		src_req[n] = 1;
		@(negedge clk);
		src_req = 24'h000000;
		@(negedge clk);
	endtask
	// waits for every noted offer to be served and returned
	task automatic drain();
		int i;
		// an offer not yet acknowledged shows no level, so the offer itself is waited out
		for (i = 0; i < 2000 && (exp_q.size() > 0 || irq_req !== 1'b0 || isl !== 4'h0); i++)
			@(negedge clk);
		if (i == 2000) begin
			n_errors++;
			finish_test();
		end
	endtask
	task automatic until_isl(logic [3:0] v);
		int i;
		for (i = 0; i < 200 && isl !== v; i++) @(negedge clk);
		cmp("in service", v, isl);
	endtask
	function automatic int lv(int n);
		return {ph[n % 6], pl[n % 6]};
	endfunction

	// each new offer takes the oldest noted vector
	always @(negedge clk) begin
		prev_req <= irq_req === 1'b1;
		if (irq_req === 1'b1 && !prev_req)
			cmp("vector", exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF, vec);
	end

	initial begin
		void'($urandom(32'h1FB625D5));
		repeat (20) @(negedge clk);
		rst = 0;
		ext_pin_a = 8'($urandom);
		ext_pin_b = 4'hF;
		repeat (3) @(negedge clk);
		cmp("global enable", 0, ea);
		cmp("reset vector", 0, vec);
		cmp("flags a", 0, fa);
		cmp("flags b", 0, fb);
		wr(VPIC_SEL_ENABLE_0, 8'h04);
		a = ok_src[$urandom % 17];
		pulse(2);
		pulse(a);
		repeat (10) @(negedge clk);
		cmp("latched", 24'h000004 | (24'h000001 << a), req_flags);
		cmp("wake", 1, wake);
		for (int c = 0; c < 2; c++) begin
			req_clr_idx = 5'(c == 0 ? a : 2);
			req_clr_en = 1;
			@(negedge clk);
			req_clr_en = 0;
			@(negedge clk);
		end
		cmp("cleared", 0, req_flags);
		pulse(2);
		exp_q.push_back(16'h0013);
		wr(VPIC_SEL_ENABLE_0, 8'h84);
		drain();
		cmp("serviced", 0, req_flags);
		// sweep every source but the external-fed ones; the pin checks below cover only sources 5 and 1
		wr(VPIC_SEL_ENABLE_0, 8'hBF);
		for (int i = 1; i < 4; i++) wr(vpic_reg_sel_t'(i), 8'h3F);
		for (int n = 0; n < 24; n++) begin
			if (n inside {0, 1, 5, 6, 11}) continue;
			slow = n[0];
			if (!(n inside {7, 23})) exp_q.push_back(16'(16'h0003 + 8 * n));
			pulse(n);
			drain();
		end
		for (int k = 0; k < 8; k++) begin
			pl = 6'($urandom);
			ph = 6'($urandom);
			wr(VPIC_SEL_PRIO_LOW, {2'h0, pl});
			wr(VPIC_SEL_PRIO_HIGH, {2'h0, ph});
			a = ok_src[$urandom % 17];
			do b = ok_src[$urandom % 17]; while (b == a);
			w = (lv(a) > lv(b) || (lv(a) == lv(b) && a < b)) ? a : b;
			exp_q.push_back(16'(3 + 8 * w));
			exp_q.push_back(16'(3 + 8 * (a + b - w)));
			src_req[a] = 1;
			src_req[b] = 1;
			@(negedge clk);
			src_req = 24'h000000;
			drain();
		end
		// source 4 waits at equal level, source 3 preempts
		pl = 6'h08;
		ph = 6'h08;
		wr(VPIC_SEL_PRIO_LOW, 8'h08);
		wr(VPIC_SEL_PRIO_HIGH, 8'h08);
		exp_q.push_back(16'h0013);
		pulse(2);
		until_isl(4'h1);
		// entry clears global enable; the routine sets it again to allow nesting
		wr(VPIC_SEL_ENABLE_0, 8'hBF);
		exp_q.push_back(16'h001B);
		exp_q.push_back(16'h0023);
		pulse(4);
		repeat (10) @(negedge clk);
		pulse(3);
		until_isl(4'h9);
		drain();
		wr(VPIC_SEL_ENABLE_0, 8'h80);
		for (int m = 0; m < 4; m++) begin
			wr(VPIC_SEL_EDGE_A_LOW, {6'h00, 2'(m)});
			ext_pin_a[0] = 0;
			repeat (3) @(negedge clk);
			cmp("fall flag", m[1], fa[0]);
			wr(VPIC_SEL_FLAGS_A, 8'hFE);
			cmp("flag write", 0, fa[0]);
			ext_pin_a[0] = 1;
			repeat (3) @(negedge clk);
			cmp("rise flag", m[0], fa[0]);
			wr(VPIC_SEL_FLAGS_A, 8'hFE);
		end
		exp_q.push_back(16'h002B);
		ext_pin_a[0] = 0;
		wr(VPIC_SEL_ENABLE_0, 8'hA0);
		drain();
		cmp("flags a entry", 0, fa);
		wr(VPIC_SEL_EDGE_B, 8'h08);
		exp_q.push_back(16'h000B);
		wr(VPIC_SEL_ENABLE_0, 8'hA2);
		ext_pin_b[1] = 0;
		drain();
		cmp("flags b entry", 0, fb);
		finish_test();
	end
endmodule

`default_nettype wire
